// file: shared/gbc_pkg.sv
// Package of command codes, bank states and timing counts for the bank command tracker
// Overview of operation
// - Read with auto precharge holds bank until row precharge time ends, then idle.
// - Write with auto precharge holds bank until row precharge time ends, then idle.
// - Refreshing lasts from auto refresh until refresh cycle time; then all banks idle.
// - Mode access lasts from mode register load until set delay; then all idle.
// - Precharge-all lasts until row precharge time; every bank idle afterwards.
// - Access period runs from activation through the last valid data nibble; the code starts it at the read or write command.
// - Commands to another bank follow that bank's state, except auto-precharge delays.
// - Idle after precharge plus row precharge time; active after activation plus row-to-column delay.
// - Read auto-precharge period starts at earliest explicit precharge still delivering burst.
// - Write auto-precharge period starts after write recovery time, ends after precharge time.
// - Chip select high ignores commands; all strobes high is no-operation; work continues.
// - Strobe codes: LHH activate, HLH read, HLL write, LHL precharge, LLH refresh, LLL mode load.
// - Refresh code is auto refresh with clock enable high, self refresh entry when low.
// - Address bit eight high selects auto precharge for that read or write.
package gbc_pkg;
    localparam int NUM_BANKS = 4;
    localparam int CLK_PERIOD_NS = 40;
    // Device timings in ns, counts rounded up to whole clocks
    localparam int ROW_PRECHARGE_TIME_NS = 15;
    localparam int REFRESH_CYCLE_TIME_NS = 60;
    localparam int MODE_REGISTER_SET_DELAY_NS = 10;
    localparam int ROW_TO_COLUMN_DELAY_NS = 15;
    localparam int WRITE_RECOVERY_TIME_NS = 15;
    localparam int BURST_LENGTH = 8;
    localparam int WRITE_LATENCY = 4;
    localparam int READ_LATENCY = 7;
    localparam int CNT_W = 6;
    localparam logic [CNT_W-1:0] RP_CYC  = CNT_W'((ROW_PRECHARGE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam logic [CNT_W-1:0] RC_CYC  = CNT_W'((REFRESH_CYCLE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam logic [CNT_W-1:0] MRD_CYC = CNT_W'((MODE_REGISTER_SET_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam logic [CNT_W-1:0] RCD_CYC = CNT_W'((ROW_TO_COLUMN_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam logic [CNT_W-1:0] WR_CYC  = CNT_W'((WRITE_RECOVERY_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam logic [CNT_W-1:0] HALF_BURST = CNT_W'(BURST_LENGTH / 2);
    // Read burst data ends after read latency plus half burst
    localparam logic [CNT_W-1:0] RD_BURST_CYC = CNT_W'(READ_LATENCY + BURST_LENGTH / 2);
    localparam logic [CNT_W-1:0] WR_BURST_CYC = CNT_W'(WRITE_LATENCY + BURST_LENGTH / 2);
    localparam logic [CNT_W-1:0] WR_TO_RD_CYC = CNT_W'(WRITE_LATENCY + BURST_LENGTH / 2) + WR_CYC;
    localparam int AP_BIT = 8;
    localparam logic [CNT_W-1:0] ONE_CYC = 6'h01;

    typedef enum logic [2:0] {
        GBC_CMD_NOP, GBC_CMD_ACT, GBC_CMD_RD, GBC_CMD_WR,
        GBC_CMD_PRE, GBC_CMD_REF, GBC_CMD_SREF, GBC_CMD_MRS
    } gbc_cmd_type;

    typedef enum logic [3:0] {
        GBC_IDLE, GBC_ACTIVATING, GBC_ACTIVE, GBC_READ, GBC_WRITE,
        GBC_READ_AP, GBC_WRITE_AP, GBC_PRECHARGING
    } gbc_bank_state_type;

    typedef enum logic [1:0] {
        GBC_DEV_NORMAL, GBC_DEV_REFRESH, GBC_DEV_MODE, GBC_DEV_PREALL
    } gbc_dev_state_type;

    // Strobe decode, chip select and strobes active low
    function automatic gbc_cmd_type decode_cmd(input logic cs_n, input logic ras_n,
                                               input logic cas_n, input logic we_n, input logic cke);
        gbc_cmd_type c;
        c = GBC_CMD_NOP;
        if (!cs_n) begin
            unique case ({ras_n, cas_n, we_n})
                3'b011: c = GBC_CMD_ACT;
                3'b101: c = GBC_CMD_RD;
                3'b100: c = GBC_CMD_WR;
                3'b010: c = GBC_CMD_PRE;
                3'b001: c = cke ? GBC_CMD_REF : GBC_CMD_SREF;
                3'b000: c = GBC_CMD_MRS;
                default: c = GBC_CMD_NOP;
            endcase
        end
        return c;
    endfunction
endpackage

// file: shared/gbc_bank_if.sv
// Interface carrying one bank's command and state between the top and a bank tracker
`timescale 1ns/100ps
interface gbc_bank_if;
    gbc_pkg::gbc_cmd_type        cmd;
    logic                        hit;
    logic                        ap;
    logic                        force_idle;
    gbc_pkg::gbc_bank_state_type state;
    logic                        burst_busy;
    logic                        in_ap_precharge;
    modport ctrl (output cmd, output hit, output ap, output force_idle,
                  input state, input burst_busy, input in_ap_precharge);
    modport bank (input cmd, input hit, input ap, input force_idle,
                  output state, output burst_busy, output in_ap_precharge);
endinterface

// file: rtl/gbc_bank.sv
// One bank state tracker with its own timing counter
`timescale 1ns/100ps
module gbc_bank (
    input wire logic   clk_sys,
    input wire logic   srst,
    gbc_bank_if.bank   bif
);
    gbc_pkg::gbc_bank_state_type st, next_st;
    logic [gbc_pkg::CNT_W-1:0]   cnt, next_cnt;
    logic                        in_pre, next_in_pre;

    // ----------------------------------------
    // Next state
    // ----------------------------------------
    always_comb begin
        next_st = st;
        next_cnt = (cnt != '0) ? cnt - gbc_pkg::ONE_CYC : cnt;
        next_in_pre = in_pre;
        if (bif.force_idle) begin
            next_st = gbc_pkg::GBC_IDLE;
            next_cnt = '0;
            next_in_pre = 1'b0;
        end else if (bif.hit && bif.cmd == gbc_pkg::GBC_CMD_ACT && st == gbc_pkg::GBC_IDLE) begin
            next_st = gbc_pkg::GBC_ACTIVATING;
            next_cnt = gbc_pkg::RCD_CYC;
        end else if (bif.hit && (bif.cmd == gbc_pkg::GBC_CMD_RD || bif.cmd == gbc_pkg::GBC_CMD_WR)
                     && (st == gbc_pkg::GBC_ACTIVE || st == gbc_pkg::GBC_READ || st == gbc_pkg::GBC_WRITE)) begin
            next_in_pre = 1'b0;
            if (bif.cmd == gbc_pkg::GBC_CMD_RD) begin
                next_st = bif.ap ? gbc_pkg::GBC_READ_AP : gbc_pkg::GBC_READ;
                // Precharge may start half a burst in, data still leaves the pins
                next_cnt = bif.ap ? gbc_pkg::HALF_BURST : gbc_pkg::RD_BURST_CYC;
            end else begin
                next_st = bif.ap ? gbc_pkg::GBC_WRITE_AP : gbc_pkg::GBC_WRITE;
                next_cnt = bif.ap ? gbc_pkg::WR_TO_RD_CYC : gbc_pkg::WR_BURST_CYC;
            end
        end else if (bif.hit && bif.cmd == gbc_pkg::GBC_CMD_PRE
                     && (st == gbc_pkg::GBC_ACTIVE || st == gbc_pkg::GBC_READ || st == gbc_pkg::GBC_WRITE)) begin
            next_st = gbc_pkg::GBC_PRECHARGING;
            next_cnt = gbc_pkg::RP_CYC;
        end else if (cnt == gbc_pkg::ONE_CYC || cnt == '0) begin
            unique case (st)
                gbc_pkg::GBC_ACTIVATING: next_st = gbc_pkg::GBC_ACTIVE;
                gbc_pkg::GBC_READ, gbc_pkg::GBC_WRITE: next_st = gbc_pkg::GBC_ACTIVE;
                gbc_pkg::GBC_PRECHARGING: next_st = gbc_pkg::GBC_IDLE;
                gbc_pkg::GBC_READ_AP, gbc_pkg::GBC_WRITE_AP: begin
                    // Access period over: run the precharge period, then idle
                    if (!in_pre) begin
                        next_in_pre = 1'b1;
                        next_cnt = gbc_pkg::RP_CYC;
                    end else begin
                        next_in_pre = 1'b0;
                        next_st = gbc_pkg::GBC_IDLE;
                    end
                end
                default: next_st = st;
            endcase
        end
    end

    // ----------------------------------------
    // Registers
    // ----------------------------------------
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            st <= gbc_pkg::GBC_IDLE;
            cnt <= '0;
            in_pre <= 1'b0;
        end else begin
            st <= next_st;
            cnt <= next_cnt;
            in_pre <= next_in_pre;
        end
    end

    assign bif.state = st;
    assign bif.burst_busy = (st == gbc_pkg::GBC_READ || st == gbc_pkg::GBC_WRITE
                             || ((st == gbc_pkg::GBC_READ_AP || st == gbc_pkg::GBC_WRITE_AP) && !in_pre));
    assign bif.in_ap_precharge = in_pre;
endmodule // gbc_bank

// file: rtl/gbc_tracker.sv
// Top: command decode, device-wide states and per-bank legality checking
`timescale 1ns/100ps
module gbc_tracker (
    input  wire logic       clk_sys,
    input  wire logic       srst,
    input  wire logic       cke,
    input  wire logic       cs_n,
    input  wire logic       ras_n,
    input  wire logic       cas_n,
    input  wire logic       we_n,
    input  wire logic [1:0] bank_addr,
    input  wire logic [11:0] addr,
    output logic [2:0]      cmd_seen,
    output logic            cmd_taken,
    output logic            cmd_illegal,
    output logic            self_refresh_req,
    output logic [1:0]      dev_state,
    output logic [3:0]      bank_idle,
    output logic [3:0]      bank_active,
    output logic [3:0]      bank_busy
);
    gbc_bank_if bif [gbc_pkg::NUM_BANKS] ();

    gbc_pkg::gbc_cmd_type        cmd;
    gbc_pkg::gbc_dev_state_type  dst, next_dst;
    logic [gbc_pkg::CNT_W-1:0]   dcnt, next_dcnt;
    logic [gbc_pkg::CNT_W-1:0]   gap, next_gap;       // Clocks since last auto-precharge access
    logic                        gap_wr, next_gap_wr; // That access was a write
    logic [1:0]                  gap_bank, next_gap_bank;
    logic                        gap_on, next_gap_on;
    logic                        legal, all_idle, any_burst, pre_all;
    logic [3:0]                  st_idle, st_act, st_busy, pre_ok;
    gbc_pkg::gbc_bank_state_type tgt;
    logic [2:0]                  next_cmd_seen;
    logic                        next_taken, next_illegal, next_sref;

    assign cmd = gbc_pkg::decode_cmd(cs_n, ras_n, cas_n, we_n, cke);
    assign pre_all = addr[gbc_pkg::AP_BIT];

    // ----------------------------------------
    // Bank trackers
    // ----------------------------------------
    for (genvar b = 0; b < gbc_pkg::NUM_BANKS; b++) begin : g_bank
        // Each bank sees every legal command, illegal ones as no-operation, and filters by address
        assign bif[b].cmd = legal ? cmd : gbc_pkg::GBC_CMD_NOP;
        assign bif[b].hit = (bank_addr == 2'(b)) || (cmd == gbc_pkg::GBC_CMD_PRE && pre_all);
        assign bif[b].ap = addr[gbc_pkg::AP_BIT];
        assign bif[b].force_idle = (dst != gbc_pkg::GBC_DEV_NORMAL) && (dcnt == '0);
        assign st_idle[b] = (bif[b].state == gbc_pkg::GBC_IDLE);
        assign st_act[b]  = (bif[b].state == gbc_pkg::GBC_ACTIVE);
        assign st_busy[b] = bif[b].burst_busy;
        assign pre_ok[b]  = st_idle[b] || st_act[b] || bif[b].state == gbc_pkg::GBC_PRECHARGING;
        gbc_bank u_bank (
            .clk_sys (clk_sys),
            .srst    (srst),
            .bif     (bif[b])
        );
    end

    assign all_idle = &st_idle;
    assign any_burst = |st_busy;

    // ----------------------------------------
    // Legality of the present command
    // ----------------------------------------
    always_comb begin
        tgt = gbc_pkg::GBC_IDLE;
        unique case (bank_addr)
            2'h0: tgt = bif[0].state;
            2'h1: tgt = bif[1].state;
            2'h2: tgt = bif[2].state;
            2'h3: tgt = bif[3].state;
        endcase
        legal = 1'b1;
        if (dst != gbc_pkg::GBC_DEV_NORMAL) begin
            legal = (cmd == gbc_pkg::GBC_CMD_NOP);
        end else begin
            unique case (cmd)
                gbc_pkg::GBC_CMD_NOP: legal = 1'b1;
                gbc_pkg::GBC_CMD_ACT: legal = (tgt == gbc_pkg::GBC_IDLE);
                gbc_pkg::GBC_CMD_RD:  legal = (tgt == gbc_pkg::GBC_ACTIVE || tgt == gbc_pkg::GBC_READ
                                               || tgt == gbc_pkg::GBC_WRITE);
                gbc_pkg::GBC_CMD_WR:  legal = (tgt == gbc_pkg::GBC_ACTIVE || tgt == gbc_pkg::GBC_WRITE);
                gbc_pkg::GBC_CMD_PRE: legal = pre_all ? (&pre_ok) : (tgt != gbc_pkg::GBC_ACTIVATING);
                gbc_pkg::GBC_CMD_REF, gbc_pkg::GBC_CMD_MRS,
                gbc_pkg::GBC_CMD_SREF: legal = all_idle && !any_burst;
            endcase
            // Spacing after an auto-precharge access to a different bank
            if (gap_on && bank_addr != gap_bank && cmd != gbc_pkg::GBC_CMD_NOP) begin
                if (cmd == gbc_pkg::GBC_CMD_RD && gap_wr && gap < gbc_pkg::WR_TO_RD_CYC)
                    legal = 1'b0;
                else if ((cmd == gbc_pkg::GBC_CMD_RD && !gap_wr) || (cmd == gbc_pkg::GBC_CMD_WR && gap_wr))
                    legal = legal && (gap >= gbc_pkg::HALF_BURST);
                else if (cmd == gbc_pkg::GBC_CMD_WR && !gap_wr)
                    legal = legal && (gap >= gbc_pkg::RD_BURST_CYC);
                else
                    legal = legal && (gap >= gbc_pkg::ONE_CYC);
            end
        end
    end

    // ----------------------------------------
    // Device-wide state and spacing counter
    // ----------------------------------------
    always_comb begin
        next_dst = dst;
        next_dcnt = (dcnt != '0) ? dcnt - gbc_pkg::ONE_CYC : dcnt;
        if (dst != gbc_pkg::GBC_DEV_NORMAL && dcnt == '0)
            next_dst = gbc_pkg::GBC_DEV_NORMAL;
        else if (dst == gbc_pkg::GBC_DEV_NORMAL && legal) begin
            if (cmd == gbc_pkg::GBC_CMD_REF) begin
                next_dst = gbc_pkg::GBC_DEV_REFRESH;
                next_dcnt = gbc_pkg::RC_CYC - gbc_pkg::ONE_CYC;
            end else if (cmd == gbc_pkg::GBC_CMD_MRS) begin
                next_dst = gbc_pkg::GBC_DEV_MODE;
                next_dcnt = gbc_pkg::MRD_CYC - gbc_pkg::ONE_CYC;
            end else if (cmd == gbc_pkg::GBC_CMD_PRE && pre_all) begin
                next_dst = gbc_pkg::GBC_DEV_PREALL;
                next_dcnt = gbc_pkg::RP_CYC - gbc_pkg::ONE_CYC;
            end
        end
        next_gap = (gap != '1) ? gap + gbc_pkg::ONE_CYC : gap;
        next_gap_wr = gap_wr;
        next_gap_bank = gap_bank;
        next_gap_on = gap_on;
        if (legal && (cmd == gbc_pkg::GBC_CMD_RD || cmd == gbc_pkg::GBC_CMD_WR)
            && addr[gbc_pkg::AP_BIT]) begin
            next_gap = gbc_pkg::ONE_CYC;
            next_gap_wr = (cmd == gbc_pkg::GBC_CMD_WR);
            next_gap_bank = bank_addr;
            next_gap_on = 1'b1;
        end else if (gap >= gbc_pkg::WR_TO_RD_CYC && gap >= gbc_pkg::RD_BURST_CYC)
            next_gap_on = 1'b0;
        next_cmd_seen = 3'(cmd);
        next_taken = legal && cmd != gbc_pkg::GBC_CMD_NOP;
        next_illegal = !legal;
        next_sref = legal && cmd == gbc_pkg::GBC_CMD_SREF;
    end

    // ----------------------------------------
    // Registers, all outputs from flip-flops
    // ----------------------------------------
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            dst <= gbc_pkg::GBC_DEV_NORMAL;
            dcnt <= '0;
            gap <= '0;
            gap_wr <= 1'b0;
            gap_bank <= 2'h0;
            gap_on <= 1'b0;
            cmd_seen <= 3'h0;
            cmd_taken <= 1'b0;
            cmd_illegal <= 1'b0;
            self_refresh_req <= 1'b0;
            dev_state <= 2'h0;
            bank_idle <= 4'hF;
            bank_active <= 4'h0;
            bank_busy <= 4'h0;
        end else begin
            dst <= next_dst;
            dcnt <= next_dcnt;
            gap <= next_gap;
            gap_wr <= next_gap_wr;
            gap_bank <= next_gap_bank;
            gap_on <= next_gap_on;
            cmd_seen <= next_cmd_seen;
            cmd_taken <= next_taken;
            cmd_illegal <= next_illegal;
            self_refresh_req <= next_sref;
            dev_state <= 2'(next_dst);
            bank_idle <= st_idle;
            bank_active <= st_act;
            bank_busy <= st_busy;
        end
    end
endmodule // gbc_tracker

// file: testbench/gbc_tracker_sva.sv
// Checker of command decode and device state relations at the tracker ports
`timescale 1ns/100ps
module gbc_tracker_sva (
    input wire logic        clk_sys,
    input wire logic        srst,
    input wire logic        cke,
    input wire logic        cs_n,
    input wire logic        ras_n,
    input wire logic        cas_n,
    input wire logic        we_n,
    input wire logic [2:0]  cmd_seen,
    input wire logic        cmd_taken,
    input wire logic        cmd_illegal,
    input wire logic        self_refresh_req,
    input wire logic [1:0]  dev_state,
    input wire logic [3:0]  bank_idle,
    input wire logic [3:0]  bank_active,
    input wire logic [3:0]  bank_busy
);
    // ------------------------------------------------
    // Properties, one clock domain
    // ------------------------------------------------
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (srst);
    property p_one_answer; !(cmd_taken && cmd_illegal); endproperty
    a_one_answer: assert property (p_one_answer) else $error("taken and illegal together");
    property p_deselect; cs_n |=> !cmd_taken && !cmd_illegal && cmd_seen == 3'h0; endproperty
    a_deselect: assert property (p_deselect) else $error("deselect not ignored");
    property p_nop; !cs_n && ras_n && cas_n && we_n |=> cmd_seen == 3'h0 && !cmd_taken; endproperty
    a_nop: assert property (p_nop) else $error("nop acted on");
    property p_act_code; !cs_n && !ras_n && cas_n && we_n |=> cmd_seen == 3'h1; endproperty
    a_act_code: assert property (p_act_code) else $error("activate decode wrong");
    property p_rd_code; !cs_n && ras_n && !cas_n && we_n |=> cmd_seen == 3'h2; endproperty
    a_rd_code: assert property (p_rd_code) else $error("read decode wrong");
    property p_pre_code; !cs_n && !ras_n && cas_n && !we_n |=> cmd_seen == 3'h4; endproperty
    a_pre_code: assert property (p_pre_code) else $error("precharge decode wrong");
    property p_sref; self_refresh_req |-> cmd_seen == 3'h6 && !cmd_illegal; endproperty
    a_sref: assert property (p_sref) else $error("self refresh request without its code");
    property p_ref_idle; cmd_taken && cmd_seen == 3'h5 |-> bank_idle == 4'hF; endproperty
    a_ref_idle: assert property (p_ref_idle) else $error("refresh taken with a bank open");
    property p_ref_span; cmd_taken && cmd_seen == 3'h5 |-> ##[0:1] dev_state == 2'h1 ##[1:3] dev_state == 2'h0;
    endproperty
    a_ref_span: assert property (p_ref_span) else $error("refreshing span wrong");
    property p_mode; cmd_taken && cmd_seen == 3'h7 |-> ##[0:1] dev_state == 2'h2; endproperty
    a_mode: assert property (p_mode) else $error("mode access state missing");
    property p_excl; (bank_idle & (bank_active | bank_busy)) == 4'h0; endproperty
    a_excl: assert property (p_excl) else $error("bank idle and open together");
    // Main scenarios reached
    c_rd: cover property (cmd_taken && cmd_seen == 3'h2);
    c_ref: cover property (dev_state == 2'h1);
    c_sref: cover property (self_refresh_req);
endmodule // gbc_tracker_sva

bind gbc_tracker gbc_tracker_sva chk_u (.clk_sys(clk_sys), .srst(srst), .cke(cke), .cs_n(cs_n), .ras_n(ras_n),
    .cas_n(cas_n), .we_n(we_n), .cmd_seen(cmd_seen), .cmd_taken(cmd_taken), .cmd_illegal(cmd_illegal),
    .self_refresh_req(self_refresh_req), .dev_state(dev_state), .bank_idle(bank_idle),
    .bank_active(bank_active), .bank_busy(bank_busy));

// file: testbench/gbc_ctrl_model.sv
// Memory controller model driving the command pins one command at a time
`timescale 1ns/100ps
module gbc_ctrl_model (
    input  wire logic        clk_sys,
    output logic             cke,
    output wire logic        cs_n,
    output wire logic        ras_n,
    output wire logic        cas_n,
    output wire logic        we_n,
    output logic [1:0]       bank_addr,
    output logic [11:0]      addr
);
    // ------------------------------------------------
    // Pin drive
    // ------------------------------------------------
    logic [3:0] pins;
    // Pins packed as chip select, row, column, write strobes
    assign {cs_n, ras_n, cas_n, we_n} = pins;
    // Start deselected with clock enable high
    initial begin
        pins = 4'hF;
        cke = 1'b1;
        bank_addr = 2'h0;
        addr = 12'h000;
    end
    // Called at a rising edge; after the command the address lines show the inverse, not a stale value
    task automatic issue(input logic [3:0] p, input logic [1:0] b, input logic ap_sel, input logic ck);
        pins <= p;
        bank_addr <= b;
        addr <= {3'h0, ap_sel, 8'h00};
        cke <= ck;
        @(posedge clk_sys);
        pins <= 4'h7;
        bank_addr <= ~b;
        addr <= ~{3'h0, ap_sel, 8'h00};
        cke <= 1'b1;
    endtask
endmodule // gbc_ctrl_model

// file: testbench/gbc_tracker_test.sv
// Self-checking bench of the bank command tracker
`timescale 1ns/100ps
module gbc_tracker_test;
    // ------------------------------------------------
    // Signals, instances, clock
    // ------------------------------------------------
    localparam logic [3:0] P_DES = 4'hF, P_NOP = 4'h7, P_ACT = 4'h3, P_RD = 4'h5;
    localparam logic [3:0] P_WR = 4'h4, P_PRE = 4'h2, P_REF = 4'h1, P_MRS = 4'h0;
    logic clk_sys = 1'b0;
    logic srst = 1'b1;
    wire logic cke, cs_n, ras_n, cas_n, we_n;
    wire logic [1:0] bank_addr;
    wire logic [11:0] addr;
    logic [2:0] cmd_seen;
    logic cmd_taken, cmd_illegal, self_refresh_req;
    logic [1:0] dev_state;
    logic [3:0] bank_idle, bank_active, bank_busy;
    int fails = 0;
    int comparisons = 0;
    gbc_ctrl_model ctrl_u (.clk_sys(clk_sys), .cke(cke), .cs_n(cs_n), .ras_n(ras_n), .cas_n(cas_n),
        .we_n(we_n), .bank_addr(bank_addr), .addr(addr));
    gbc_tracker dut_u (.clk_sys(clk_sys), .srst(srst), .cke(cke), .cs_n(cs_n), .ras_n(ras_n), .cas_n(cas_n),
        .we_n(we_n), .bank_addr(bank_addr), .addr(addr), .cmd_seen(cmd_seen), .cmd_taken(cmd_taken),
        .cmd_illegal(cmd_illegal), .self_refresh_req(self_refresh_req), .dev_state(dev_state),
        .bank_idle(bank_idle), .bank_active(bank_active), .bank_busy(bank_busy));
    // 25 MHz clock
    initial forever #20 clk_sys = ~clk_sys;
    // Shared comparison with its own message
    task automatic chk(input logic ok, input string msg);
        comparisons++;
        if (ok !== 1'b1) begin
            fails++;
            $display("Error at %0t: %s", $time, msg);
        end
    endtask
    // One command, answer judged 1 ns after the sampling edge
    task automatic do_cmd(input logic [3:0] p, input logic [1:0] b, input logic ap_sel, input logic ck,
                          input logic [2:0] seen, input logic take, input logic ill);
        ctrl_u.issue(p, b, ap_sel, ck);
        #1;
        chk(cmd_seen === seen && cmd_taken === take && cmd_illegal === ill, "command answer");
        @(posedge clk_sys);
    endtask
    // Bounded wait for a bank to be idle again; limit covers access plus precharge time
    task automatic wait_idle(input int b, input int lim);
        for (int i = 0; i < lim; i++) begin
            @(posedge clk_sys);
            #1;
            if (bank_idle[b] === 1'b1) break;
        end
        chk(bank_idle[b] === 1'b1, "bank not idle in time");
        @(posedge clk_sys);
    endtask
    // ------------------------------------------------
    // Scenarios
    // ------------------------------------------------
    task automatic t_decode;
        do_cmd(P_DES, 2'h0, 1'b0, 1'b1, 3'h0, 1'b0, 1'b0);
        do_cmd(P_NOP, 2'h0, 1'b0, 1'b1, 3'h0, 1'b0, 1'b0);
        do_cmd(P_RD, 2'h0, 1'b0, 1'b1, 3'h2, 1'b0, 1'b1);
        do_cmd(P_ACT, 2'h0, 1'b0, 1'b1, 3'h1, 1'b1, 1'b0);
        do_cmd(P_ACT, 2'h0, 1'b0, 1'b1, 3'h1, 1'b0, 1'b1);
        // Look past the edge so the registered bank flags have settled
        #1;
        chk(bank_active[0] === 1'b1 && bank_busy[0] === 1'b0, "bank not row active");
        @(posedge clk_sys);
        do_cmd(P_PRE, 2'h0, 1'b0, 1'b1, 3'h4, 1'b1, 1'b0);
        wait_idle(0, 6);
    endtask
    task automatic t_read_ap;
        do_cmd(P_ACT, 2'h0, 1'b0, 1'b1, 3'h1, 1'b1, 1'b0);
        do_cmd(P_RD, 2'h0, 1'b1, 1'b1, 3'h2, 1'b1, 1'b0);
        #1;
        chk(bank_idle[0] === 1'b0 && bank_busy[0] === 1'b1, "read auto precharge bank idle early");
        @(posedge clk_sys);
        do_cmd(P_ACT, 2'h1, 1'b0, 1'b1, 3'h1, 1'b1, 1'b0);
        do_cmd(P_RD, 2'h0, 1'b0, 1'b1, 3'h2, 1'b0, 1'b1);
        wait_idle(0, 14);
    endtask
    task automatic t_write_ap;
        // Write to another bank too soon after the read with auto precharge
        do_cmd(P_WR, 2'h1, 1'b1, 1'b1, 3'h3, 1'b0, 1'b1);
        repeat (2) @(posedge clk_sys);
        do_cmd(P_WR, 2'h1, 1'b1, 1'b1, 3'h3, 1'b1, 1'b0);
        do_cmd(P_ACT, 2'h2, 1'b0, 1'b1, 3'h1, 1'b1, 1'b0);
        do_cmd(P_RD, 2'h2, 1'b0, 1'b1, 3'h2, 1'b0, 1'b1);
        // Next read lands exactly on the write-to-read spacing
        repeat (3) @(posedge clk_sys);
        do_cmd(P_RD, 2'h2, 1'b0, 1'b1, 3'h2, 1'b1, 1'b0);
        do_cmd(P_WR, 2'h2, 1'b0, 1'b1, 3'h3, 1'b0, 1'b1);
        wait_idle(1, 16);
        repeat (12) @(posedge clk_sys);
        do_cmd(P_PRE, 2'h2, 1'b0, 1'b1, 3'h4, 1'b1, 1'b0);
        wait_idle(2, 6);
    endtask
    task automatic t_device;
        do_cmd(P_ACT, 2'h3, 1'b0, 1'b1, 3'h1, 1'b1, 1'b0);
        do_cmd(P_REF, 2'h0, 1'b0, 1'b1, 3'h5, 1'b0, 1'b1);
        ctrl_u.issue(P_PRE, 2'h0, 1'b1, 1'b1);
        #1;
        chk(cmd_taken === 1'b1 && dev_state === 2'h3, "precharge all not entered");
        @(posedge clk_sys);
        wait_idle(3, 6);
        #1;
        chk(bank_idle === 4'hF, "banks not all idle");
        @(posedge clk_sys);
        ctrl_u.issue(P_REF, 2'h0, 1'b0, 1'b1);
        #1;
        chk(cmd_taken === 1'b1 && dev_state === 2'h1, "refresh not entered");
        repeat (4) @(posedge clk_sys);
        #1;
        chk(dev_state === 2'h0 && bank_idle === 4'hF, "refresh did not end");
        @(posedge clk_sys);
        ctrl_u.issue(P_MRS, 2'h0, 1'b0, 1'b1);
        #1;
        chk(cmd_taken === 1'b1 && dev_state === 2'h2, "mode access not entered");
        repeat (4) @(posedge clk_sys);
        ctrl_u.issue(P_REF, 2'h0, 1'b0, 1'b0);
        #1;
        chk(cmd_seen === 3'h6 && cmd_taken === 1'b1 && self_refresh_req === 1'b1, "self refresh not requested");
        @(posedge clk_sys);
        #1;
        chk(self_refresh_req === 1'b0, "self refresh request not a pulse");
    endtask
    // ------------------------------------------------
    // Run control
    // ------------------------------------------------
    task automatic wrap_up;
        $display("comparisons=%0d fails=%0d", comparisons, fails);
        if (fails == 0 && comparisons > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    // Main sequence after a 16 cycle reset
    initial begin
        repeat (16) @(posedge clk_sys);
        srst <= 1'b0;
        @(posedge clk_sys);
        #1;
        chk(bank_idle === 4'hF && dev_state === 2'h0 && cmd_taken === 1'b0, "reset values");
        @(posedge clk_sys);
        t_decode;
        t_read_ap;
        t_write_ap;
        t_device;
        wrap_up;
    end
    // Watchdog at 3000 cycles, well beyond the hundred or so cycles the scenarios take
    initial begin
        #(40 * 3000);
        fails++;
        wrap_up;
    end
endmodule // gbc_tracker_test
